/* verilog/dbs_pkg.sv */
// Constants, carrier types and the column address helper of the DDR2 burst device.
// Function
// - Burst length four: reads every second clock stream back to back without idle beats.
// - Burst length eight: reads every fourth clock stream without gaps.
// - Burst length four: writes every second clock are accepted without gaps.
// - Burst length eight: writes every fourth clock are accepted seamlessly.
// - Write latency is read latency minus one clock.
`default_nettype none
package dbs_pkg;
  localparam int DQ_W       = 16;
  localparam int ADDR_W     = 13;
  localparam int BANK_W     = 3;
  localparam int NBANKS     = 8;
  localparam int COL_W      = 5;
  localparam int MEM_AW     = BANK_W + COL_W;
  localparam int LAT_W      = 4;
  localparam int PIPE_DEPTH = 16;
  localparam int CNT_W      = 8;

  // Command codes as {cs_n, ras_n, cas_n, we_n}.
  localparam logic [3:0] CMD_MODE      = 4'h0;
  localparam logic [3:0] CMD_REFRESH   = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
  localparam logic [3:0] CMD_WRITE     = 4'h4;
  localparam logic [3:0] CMD_READ      = 4'h5;
  localparam logic [3:0] CMD_NOP       = 4'h7;

  localparam int AP_BIT = 10;
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam int CL_LSB = 4;
  localparam int CL_MSB = 6;
  localparam int AL_LSB = 3;
  localparam int AL_MSB = 5;

  localparam logic [BANK_W-1:0] MR_BANK   = 3'h0;
  localparam logic [BANK_W-1:0] EMR1_BANK = 3'h1;
  localparam logic [2:0]        BL8_CODE  = 3'h3;
  localparam logic [2:0]        CL_RESET  = 3'h3;
  localparam logic [2:0]        AL_RESET  = 3'h0;

  localparam logic [3:0]       BEATS_BL4 = 4'h4;
  localparam logic [3:0]       BEATS_BL8 = 4'h8;
  localparam logic [CNT_W-1:0] CLKS_BL4  = 8'h02;
  localparam logic [CNT_W-1:0] CLKS_BL8  = 8'h04;
  localparam logic [CNT_W-1:0] CNT_MAX   = 8'hFF;

  localparam logic [CNT_W-1:0] READ_EXIT_DEF    = 8'hC8;
  localparam logic [CNT_W-1:0] NONREAD_EXIT_DEF = 8'h1A;
  localparam logic [CNT_W-1:0] TERM_OFF_DEF     = 8'h03;

  typedef struct packed {
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              term;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } dbs_pins_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              len8;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0]  col;
  } dbs_col_cmd_t;

  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SELF_REFRESH,
    ST_EXIT_WAIT
  } dbs_state_t;

  // Sequential burst order wraps inside the burst-aligned column block.
  function automatic logic [COL_W-1:0] burst_col(
    input logic [COL_W-1:0] base,
    input logic [2:0]       beat,
    input logic             len8
  );
    logic [COL_W-1:0] col;
    col = base;
    if (len8) begin
      col[2:0] = base[2:0] + beat;
    end else begin
      col[1:0] = base[1:0] + beat[1:0];
    end
    return col;
  endfunction
endpackage
`default_nettype wire

/* verilog/dbs_cmd_delay.sv */
// Delay line that replays column commands after the read and write latencies.
`timescale 1ns/10ps
`default_nettype none
module dbs_cmd_delay
  import dbs_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         shift,
  input  wire dbs_col_cmd_t cmd_in,
  input  wire logic [LAT_W-1:0] rd_lat,
  input  wire logic [LAT_W-1:0] wr_lat,
  output var  dbs_col_cmd_t rd_tap,
  output var  dbs_col_cmd_t wr_tap
);
  dbs_col_cmd_t pipe [PIPE_DEPTH];

  // Entry 0 holds the command of the previous link clock, so a latency of
  // L clocks is read at index L-1 on the L-th rising edge.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe[i] <= '0;
      end
    end else if (shift) begin
      pipe[0] <= cmd_in;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe[i] <= pipe[i-1];
      end
    end
  end

  assign rd_tap = pipe[rd_lat - 4'h1];
  assign wr_tap = pipe[wr_lat - 4'h1];
endmodule
`default_nettype wire

/* verilog/dbs_ddr2_device.sv */
// Command decoder, burst engines and self refresh sequencing of the device.
`timescale 1ns/10ps
`default_nettype none
module dbs_ddr2_device
  import dbs_pkg::*;
#(
  parameter logic [CNT_W-1:0] READ_EXIT_CLKS    = READ_EXIT_DEF,
  parameter logic [CNT_W-1:0] NONREAD_EXIT_CLKS = NONREAD_EXIT_DEF,
  parameter logic [CNT_W-1:0] TERM_OFF_CLKS     = TERM_OFF_DEF
)
(
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic            link_clk,
  input  wire dbs_pins_t       pins,
  input  wire logic [DQ_W-1:0] dq_in,
  output logic      [DQ_W-1:0] dq_out,
  output logic                 dq_oe,
  output logic                 term_enable,
  output logic                 self_refresh,
  output logic                 protocol_error
);
  // Pin synchronisers; pins and data are looked at from the second stage, the link clock from the second and third.
  logic            clk_s1;
  logic            clk_s2;
  logic            clk_s3;
  dbs_pins_t       pins_s1;
  dbs_pins_t       pins_s2;
  logic [DQ_W-1:0] dq_s1;
  logic [DQ_W-1:0] dq_s2;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      clk_s1  <= 1'b0;
      clk_s2  <= 1'b0;
      clk_s3  <= 1'b0;
      pins_s1 <= '0;
      pins_s2 <= '0;
      dq_s1   <= '0;
      dq_s2   <= '0;
    end else begin
      clk_s1  <= link_clk;
      clk_s2  <= clk_s1;
      clk_s3  <= clk_s2;
      pins_s1 <= pins;
      pins_s2 <= pins_s1;
      dq_s1   <= dq_in;
      dq_s2   <= dq_s1;
    end
  end

  wire logic rise = clk_s2 & ~clk_s3;
  wire logic fall = ~clk_s2 & clk_s3;
  wire logic edge_any = rise | fall;

  dbs_state_t        state;
  dbs_state_t        next_state;
  logic [NBANKS-1:0] bank_open;
  logic              burst_len8;
  logic [2:0]        column_access_latency;
  logic [2:0]        additive_latency;
  logic [CNT_W-1:0]  exit_cnt;
  logic [CNT_W-1:0]  cas_gap;
  logic [CNT_W-1:0]  term_low_cnt;

  wire logic [3:0] cmd_code = {pins_s2.cs_n, pins_s2.ras_n,
                               pins_s2.cas_n, pins_s2.we_n};
  wire logic live = rise & pins_s2.cke;
  wire logic is_rd = live & (cmd_code == CMD_READ);
  wire logic is_wr = live & (cmd_code == CMD_WRITE);
  wire logic is_act = live & (cmd_code == CMD_ACTIVATE);
  wire logic is_pre = live & (cmd_code == CMD_PRECHARGE);
  wire logic is_mrs = live & (cmd_code == CMD_MODE);
  wire logic is_other = live & ~pins_s2.cs_n & (cmd_code != CMD_READ)
                        & (cmd_code != CMD_NOP);

  wire logic in_act = (state == ST_ACTIVE);
  wire logic in_exit = (state == ST_EXIT_WAIT);
  wire logic read_ok = in_act | (in_exit & (exit_cnt >= READ_EXIT_CLKS));
  wire logic other_ok = in_act
                        | (in_exit & (exit_cnt >= NONREAD_EXIT_CLKS));

  wire logic [LAT_W-1:0] read_latency = {1'b0, additive_latency}
                                        + {1'b0, column_access_latency};
  wire logic [LAT_W-1:0] write_latency = read_latency - 4'h1;

  wire logic [CNT_W-1:0] burst_clks = burst_len8 ? CLKS_BL8 : CLKS_BL4;
  wire logic bank_closed = ~bank_open[pins_s2.bank];
  // Closer spacing than one burst would overlap beats on the data bus.
  wire logic col_bad = (is_rd | is_wr) & (bank_closed
                       | (cas_gap < burst_clks));
  wire logic rd_go = is_rd & read_ok & ~col_bad;
  wire logic wr_go = is_wr & other_ok & ~col_bad;
  wire logic act_go = is_act & other_ok;
  wire logic pre_go = is_pre & other_ok;
  wire logic mrs_go = is_mrs & other_ok;
  wire logic auto_pre = pins_s2.addr[AP_BIT];

  wire logic sr_enter = rise & in_act & ~pins_s2.cke
                        & (cmd_code == CMD_REFRESH);
  wire logic sr_bad = sr_enter & ((|bank_open)
                      | pins_s2.term | (term_low_cnt < TERM_OFF_CLKS));
  wire logic exit_bad = in_exit & ((is_rd & ~read_ok)
                        | (is_other & ~other_ok)
                        | (rise & pins_s2.term & ~read_ok));

  always_comb begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        if (sr_enter) begin
          next_state = ST_SELF_REFRESH;
        end
      end
      ST_SELF_REFRESH: begin
        if (rise & pins_s2.cke) begin
          next_state = ST_EXIT_WAIT;
        end
      end
      ST_EXIT_WAIT: begin
        if (rise & (exit_cnt >= READ_EXIT_CLKS)) begin
          next_state = ST_ACTIVE;
        end
      end
      default: begin
        next_state = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state          <= ST_ACTIVE;
      self_refresh   <= 1'b0;
      protocol_error <= 1'b0;
      term_enable    <= 1'b0;
    end else begin
      state          <= next_state;
      self_refresh   <= (next_state == ST_SELF_REFRESH);
      protocol_error <= col_bad | sr_bad | exit_bad;
      // Termination is dropped on the entry edge even if the controller
      // left it high, so it never stands during self refresh.
      term_enable    <= pins_s2.term & read_ok & ~sr_enter;
    end
  end

  // Link clock counters, all saturating.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      exit_cnt     <= '0;
      cas_gap      <= CNT_MAX;
      term_low_cnt <= '0;
    end else if (rise) begin
      if (state == ST_SELF_REFRESH) begin
        exit_cnt <= 8'h01;
      end else if (in_exit & (exit_cnt != CNT_MAX)) begin
        exit_cnt <= exit_cnt + 8'h01;
      end
      if (rd_go | wr_go) begin
        cas_gap <= 8'h01;
      end else if (cas_gap != CNT_MAX) begin
        cas_gap <= cas_gap + 8'h01;
      end
      if (pins_s2.term) begin
        term_low_cnt <= '0;
      end else if (term_low_cnt != CNT_MAX) begin
        term_low_cnt <= term_low_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bank_open <= '0;
    end else if (act_go) begin
      bank_open[pins_s2.bank] <= 1'b1;
    end else if (pre_go & auto_pre) begin
      bank_open <= '0;
    end else if (pre_go | ((rd_go | wr_go) & auto_pre)) begin
      bank_open[pins_s2.bank] <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      burst_len8            <= 1'b0;
      column_access_latency <= CL_RESET;
      additive_latency      <= AL_RESET;
    end else if (mrs_go & (pins_s2.bank == MR_BANK)) begin
      burst_len8            <= (pins_s2.addr[BL_MSB:BL_LSB] == BL8_CODE);
      column_access_latency <= pins_s2.addr[CL_MSB:CL_LSB];
    end else if (mrs_go & (pins_s2.bank == EMR1_BANK)) begin
      additive_latency      <= pins_s2.addr[AL_MSB:AL_LSB];
    end
  end

  dbs_col_cmd_t col_cmd;
  dbs_col_cmd_t rd_tap;
  dbs_col_cmd_t wr_tap;

  assign col_cmd = '{valid: rd_go | wr_go, write: wr_go, len8: burst_len8,
                     bank: pins_s2.bank, col: pins_s2.addr[COL_W-1:0]};

  dbs_cmd_delay u_delay (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .shift  (rise),
    .cmd_in (col_cmd),
    .rd_lat (read_latency),
    .wr_lat (write_latency),
    .rd_tap (rd_tap),
    .wr_tap (wr_tap)
  );

  logic [DQ_W-1:0] mem [1 << MEM_AW];

  // Read burst engine: a new burst starting on the rising edge right after
  // the last falling-edge beat of the previous one leaves no idle beat.
  logic [3:0]        rd_left;
  logic [2:0]        rd_beat;
  logic [BANK_W-1:0] rd_bank;
  logic [COL_W-1:0]  rd_col;
  logic              rd_len8;

  wire logic rd_start = rise & rd_tap.valid & ~rd_tap.write;
  wire logic rd_step = edge_any & ~rd_start & (rd_left != 4'h0);
  wire logic [3:0] rd_beats = rd_tap.len8 ? BEATS_BL8 : BEATS_BL4;
  wire logic [MEM_AW-1:0] rd_addr = rd_start
       ? {rd_tap.bank, burst_col(rd_tap.col, 3'h0, rd_tap.len8)}
       : {rd_bank, burst_col(rd_col, rd_beat, rd_len8)};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_left <= '0;
      rd_beat <= '0;
      rd_bank <= '0;
      rd_col  <= '0;
      rd_len8 <= 1'b0;
      dq_out  <= '0;
      dq_oe   <= 1'b0;
    end else if (rd_start) begin
      rd_left <= rd_beats - 4'h1;
      rd_beat <= 3'h1;
      rd_bank <= rd_tap.bank;
      rd_col  <= rd_tap.col;
      rd_len8 <= rd_tap.len8;
      dq_out  <= mem[rd_addr];
      dq_oe   <= 1'b1;
    end else if (rd_step) begin
      rd_left <= rd_left - 4'h1;
      rd_beat <= rd_beat + 3'h1;
      dq_out  <= mem[rd_addr];
    end else if (edge_any) begin
      dq_oe   <= 1'b0;
    end
  end

  // Write burst engine, one cycle earlier in link clocks than reads.
  logic [3:0]        wr_left;
  logic [2:0]        wr_beat;
  logic [BANK_W-1:0] wr_bank;
  logic [COL_W-1:0]  wr_col;
  logic              wr_len8;

  wire logic wr_start = rise & wr_tap.valid & wr_tap.write;
  wire logic wr_step = edge_any & ~wr_start & (wr_left != 4'h0);
  wire logic [3:0] wr_beats = wr_tap.len8 ? BEATS_BL8 : BEATS_BL4;
  wire logic [MEM_AW-1:0] wr_addr = wr_start
       ? {wr_tap.bank, burst_col(wr_tap.col, 3'h0, wr_tap.len8)}
       : {wr_bank, burst_col(wr_col, wr_beat, wr_len8)};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_left <= '0;
      wr_beat <= '0;
      wr_bank <= '0;
      wr_col  <= '0;
      wr_len8 <= 1'b0;
    end else if (wr_start) begin
      wr_left <= wr_beats - 4'h1;
      wr_beat <= 3'h1;
      wr_bank <= wr_tap.bank;
      wr_col  <= wr_tap.col;
      wr_len8 <= wr_tap.len8;
    end else if (wr_step) begin
      wr_left <= wr_left - 4'h1;
      wr_beat <= wr_beat + 3'h1;
    end
  end

  // The array keeps no reset; its content is undefined until written.
  always_ff @(posedge mclk) begin
    if (wr_start | wr_step) begin
      mem[wr_addr] <= dq_s2;
    end
  end
endmodule
`default_nettype wire

/* bench/dbs_ddr2_properties.sv */
// Concurrent checks on the burst device outputs and self refresh flags.
`timescale 1ns/10ps
`default_nettype none
module dbs_ddr2_properties
  import dbs_pkg::*;
(
  input wire logic            mclk,
  input wire logic            rst_n,
  input wire logic            link_clk,
  input wire dbs_pins_t       pins,
  input wire logic [DQ_W-1:0] dq_in,
  input wire logic [DQ_W-1:0] dq_out,
  input wire logic            dq_oe,
  input wire logic            term_enable,
  input wire logic            self_refresh,
  input wire logic            protocol_error
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Half a burst of four is one link clock, eight system clocks.
  sequence s_half;
    dq_oe [*8];
  endsequence
  property p_rst_quiet;
    disable iff (1'b0)
    !rst_n |=> !(dq_oe | term_enable | self_refresh | protocol_error);
  endproperty
  property p_err_pulse;
    protocol_error |=> !protocol_error;
  endproperty
  property p_sr_term;
    self_refresh |-> !term_enable;
  endproperty
  property p_sr_quiet;
    self_refresh |-> !dq_oe;
  endproperty
  property p_burst;
    $rose(dq_oe) |-> s_half ##1 s_half;
  endproperty
  // A beat may only move a few clocks after a link edge.
  property p_beat_edge;
    dq_oe && $changed(dq_out) |-> ($past(link_clk, 3) != $past(link_clk, 4))
      || ($past(link_clk, 4) != $past(link_clk, 5));
  endproperty
  property p_term_src;
    $rose(term_enable) |-> $past(pins.term, 3);
  endproperty
  property p_sr_in;
    $rose(self_refresh) |-> !pins.cke;
  endproperty
  property p_sr_out;
    $fell(self_refresh) |-> pins.cke;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset outputs");
  a_err_pulse: assert property (p_err_pulse) else $error("error width");
  a_sr_term: assert property (p_sr_term) else $error("term in sr");
  a_sr_quiet: assert property (p_sr_quiet) else $error("read in sr");
  a_burst: assert property (p_burst) else $error("short burst");
  a_beat_edge: assert property (p_beat_edge) else $error("beat time");
  a_term_src: assert property (p_term_src) else $error("term src");
  a_sr_in: assert property (p_sr_in) else $error("sr entry");
  a_sr_out: assert property (p_sr_out) else $error("sr exit");
endmodule
bind dbs_ddr2_device dbs_ddr2_properties u_dbs_ddr2_properties (
  .mclk(mclk), .rst_n(rst_n), .link_clk(link_clk), .pins(pins),
  .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
  .term_enable(term_enable), .self_refresh(self_refresh),
  .protocol_error(protocol_error));
`default_nettype wire

/* bench/dbs_ctrl_model.sv */
// Controller model: free-running link clock, command pins and write beats.
`timescale 1ns/10ps
`default_nettype none
module dbs_ctrl_model
  import dbs_pkg::*;
(
  output logic            link_clk,
  output dbs_pins_t       pins,
  output logic [DQ_W-1:0] dq_in
);
  logic [DQ_W-1:0] sched [int];
  int              hedge;
  logic            cke_l;
  logic            term_l;
  initial begin
    link_clk = 1'b0;
    pins = {1'b1, 4'hF, 1'b0, 3'h0, 13'h0000};
    dq_in = 16'h0000;
    hedge = 0;
    cke_l = 1'b1;
    term_l = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end
  // Beats change mid-phase; an unscheduled edge sees a flipped pattern.
  always @(link_clk) begin
    hedge++;
    #40;
    dq_in = sched.exists(hedge + 1) ? sched[hedge + 1] : ~dq_in;
  end
  // Pins move on the falling edge so they stand half a clock each side.
  task automatic cmd(input logic [3:0] code, input logic [2:0] b,
                     input logic [12:0] a, output int edge_no);
    @(negedge link_clk);
    pins = {cke_l, code, term_l, b, a};
    @(posedge link_clk);
    #1;
    edge_no = hedge;
  endtask
endmodule
`default_nettype wire

/* bench/dbs_ddr2_device_test.sv */
// Self-checking bench of the burst device driven by the controller model.
`timescale 1ns/10ps
`default_nettype none
module dbs_ddr2_device_test
  import dbs_pkg::*;
();
  logic            mclk;
  logic            rst_n;
  logic            link_clk;
  dbs_pins_t       pins;
  logic [DQ_W-1:0] dq_in;
  logic [DQ_W-1:0] dq_out;
  logic            dq_oe;
  logic            term_enable;
  logic            self_refresh;
  logic            protocol_error;
  logic [DQ_W-1:0] mem [int];
  logic [31:0]     exp_q [$];
  logic [31:0]     seed;
  logic            armed;
  int              n_mismatch;
  int              num_checks;
  int              n_err;
  int              e;
  int              rl;
  int              wl;
  dbs_ctrl_model u_dbs_ctrl_model (.link_clk(link_clk), .pins(pins),
    .dq_in(dq_in));
  dbs_ddr2_device #(.READ_EXIT_CLKS(8'h08), .NONREAD_EXIT_CLKS(8'h04),
    .TERM_OFF_CLKS(8'h02)) u_dbs_ddr2_device (.mclk(mclk), .rst_n(rst_n),
    .link_clk(link_clk), .pins(pins), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .term_enable(term_enable), .self_refresh(self_refresh),
    .protocol_error(protocol_error));
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (protocol_error === 1'b1) n_err++;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic c(input logic [3:0] code, input logic [2:0] b,
                   input logic [12:0] a);
    u_dbs_ctrl_model.cmd(code, b, a, e);
  endtask
  task automatic idle(input int n);
    repeat (n) c(CMD_NOP, 3'h0, 13'h0000);
  endtask
  // Column order wraps inside the aligned block of the burst.
  function automatic logic [4:0] wrap(input logic [4:0] col, input int k,
                                      input int n);
    return n == 8 ? {col[4:3], col[2:0] + 3'(k)}
                  : {col[4:2], col[1:0] + 2'(k)};
  endfunction
  task automatic wr(input logic [2:0] b, input logic [4:0] col, input int n);
    c(CMD_WRITE, b, {8'h00, col});
    for (int k = 0; k < n; k++) begin
      seed = lfsr(seed);
      mem[{b, wrap(col, k, n)}] = seed[15:0];
      u_dbs_ctrl_model.sched[e + 2 * wl + k] = seed[15:0];
    end
    idle(n / 2 - 1);
  endtask
  task automatic rd(input logic [2:0] b, input logic [4:0] col, input int n,
                    input int pad);
    c(CMD_READ, b, {8'h00, col});
    for (int k = 0; k < n; k++)
      exp_q.push_back({16'(e + 2 * rl + k), mem[{b, wrap(col, k, n)}]});
    idle(pad);
  endtask
  // Each beat is read well after it settles and before the next one.
  task automatic mon();
    int h;
    #1 h = u_dbs_ctrl_model.hedge;
    #119;
    if (dq_oe === 1'b1) begin
      chk({16'(h), dq_out}, exp_q.size() ? exp_q.pop_front() : '1);
      armed = exp_q.size() != 0;
    end else if (armed) begin
      chk({31'h0, dq_oe}, 32'h1);
    end
  endtask
  always @(posedge link_clk) mon();
  always @(negedge link_clk) mon();
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    n_err = 0;
    armed = 1'b0;
    seed = 32'h4F4E8F3B;
    rl = 3;
    wl = 2;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    c(CMD_ACTIVATE, 3'h0, 13'h0000);
    c(CMD_ACTIVATE, 3'h5, 13'h0000);
    wr(3'h0, 5'h04, 4);
    wr(3'h5, 5'h0A, 4);
    idle(3);
    rd(3'h0, 5'h06, 4, 1);
    rd(3'h5, 5'h0A, 4, 8);
    c(CMD_MODE, MR_BANK, 13'h0033);
    c(CMD_MODE, EMR1_BANK, 13'h0008);
    rl = 4;
    wl = 3;
    wr(3'h0, 5'h10, 8);
    wr(3'h5, 5'h1B, 8);
    idle(3);
    rd(3'h5, 5'h1B, 8, 3);
    rd(3'h0, 5'h13, 8, 10);
    c(CMD_READ, 3'h2, 13'h0000);
    rd(3'h0, 5'h10, 8, 0);
    c(CMD_READ, 3'h5, 13'h0000);
    idle(10);
    chk(n_err, 32'h2);
    u_dbs_ctrl_model.term_l = 1'b1;
    idle(4);
    chk({31'h0, term_enable}, 32'h1);
    u_dbs_ctrl_model.term_l = 1'b0;
    idle(3);
    c(CMD_PRECHARGE, 3'h0, 13'h0400);
    u_dbs_ctrl_model.cke_l = 1'b0;
    c(CMD_REFRESH, 3'h0, 13'h0000);
    #100;
    chk({31'h0, self_refresh}, 32'h1);
    idle(4);
    u_dbs_ctrl_model.cke_l = 1'b1;
    idle(1);
    // The exit edge is clock 0; a command at clock k is legal once k
    // reaches the delay, so the activate at clock 1 is refused and the
    // one at clock 4 is taken.
    c(CMD_ACTIVATE, 3'h0, 13'h0000);
    idle(2);
    c(CMD_ACTIVATE, 3'h0, 13'h0000);
    idle(1);
    c(CMD_READ, 3'h0, 13'h0010);
    u_dbs_ctrl_model.term_l = 1'b1;
    idle(1);
    // Sampled before the read delay is met on this edge, while the synced
    // termination request has already stood for a few system clocks.
    chk({31'h0, term_enable}, 32'h0);
    rd(3'h0, 5'h10, 8, 10);
    chk(n_err, 32'h5);
    chk({30'h0, term_enable, self_refresh}, 32'h2);
    chk(exp_q.size(), 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
